// File: bench/bcm_ctrl_properties.sv
`timescale 1ns/1ps
module bcm_ctrl_props (
   input wire sys_clk_i,
   input wire rst_b_i,
   input wire [15:0] io_addr_i,
   input wire [7:0] io_wdata_i,
   input wire io_wr_i,
   input wire io_rd_i,
   input wire [7:0] io_rdata_o,
   input wire internal_latch_strobe_o,
   input wire ale_o,
   input wire early_latch_strobe_b_o,
   input wire command_b_o,
   input wire ready_b_o,
   input wire cpu_reset_o,
   input wire nmi_o,
   input wire quick_mode_o,
   input wire [1:0] wait8_o,
   input wire [3:0] shadow_write_protect_o,
   input wire [3:0] rom_select_suppress_o,
   input wire bus_clk_en_o,
   input wire system_clock_o
);
   reg [7:0] idx_q;
   reg b5_q;
   reg rdy_en_q;
   reg nmi_en_q;
   wire wd = io_wr_i && io_addr_i == 16'h0023;
   wire w60 = wd && idx_q == 8'h60;
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_b_i);
   // shadow of the index and gate bits, only what the properties need
   always @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         idx_q <= 8'h00;
         b5_q <= 1'b0;
         rdy_en_q <= 1'b0;
         nmi_en_q <= 1'b0;
      end else begin
         if (io_wr_i && io_addr_i == 16'h0022) idx_q <= io_wdata_i;
         if (w60) b5_q <= io_wdata_i[5];
         if (w60) rdy_en_q <= io_wdata_i[2];
         if (io_wr_i && io_addr_i == 16'h0070) nmi_en_q <= io_wdata_i[7];
      end
   end
   AST_ILS_TWO: assert property ($rose(internal_latch_strobe_o) |->
      ##1 internal_latch_strobe_o ##1 !internal_latch_strobe_o) else $error("latch strobe length");
   AST_EARLY_LATCH: assert property ($rose(internal_latch_strobe_o) |->
      !early_latch_strobe_b_o) else $error("early latch strobe missing");
   AST_ALE_ORDER: assert property ($rose(ale_o) |->
      !internal_latch_strobe_o && command_b_o) else $error("bus latch out of order");
   AST_READY_AFTER: assert property ($rose(command_b_o) |-> ##[1:2] !ready_b_o)
      else $error("ready not after command");
   AST_READY_PULSE: assert property ($fell(ready_b_o) |=> ready_b_o)
      else $error("ready pulse too long");
   AST_CPU_RESET: assert property (cpu_reset_o == $past(w60 && io_wdata_i[5] && !b5_q))
      else $error("cpu reset mismatch");
   AST_NMI_GATE: assert property (nmi_o |-> rdy_en_q && nmi_en_q)
      else $error("nmi while gated");
   AST_UNMAPPED: assert property (io_rd_i && !(io_addr_i inside {16'h0022, 16'h0023,
      16'h0061, 16'h0070}) |-> io_rdata_o == 8'h00) else $error("unmapped read data");
   AST_QUICK: assert property (wd && idx_q == 8'h61 |=>
      quick_mode_o == !$past(io_wdata_i[6])) else $error("quick mode polarity");
   AST_WAIT8: assert property (wd && idx_q == 8'h62 |=> wait8_o == $past(io_wdata_i[3:2]))
      else $error("8-bit wait field");
   AST_ROM: assert property (wd && idx_q == 8'h65 |=>
      {shadow_write_protect_o, rom_select_suppress_o} == $past(io_wdata_i)) else $error("rom cfg");
   AST_SYSTEM_CLOCK_OUT: assert property ($changed(system_clock_o) == $past(bus_clk_en_o, 2))
      else $error("system clock not bus clock halved");
endmodule // bcm_ctrl_props
bind bcm_ctrl bcm_ctrl_props u_props (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
   .io_addr_i(io_addr_i), .io_wdata_i(io_wdata_i), .io_wr_i(io_wr_i), .io_rd_i(io_rd_i),
   .io_rdata_o(io_rdata_o), .internal_latch_strobe_o(internal_latch_strobe_o), .ale_o(ale_o),
   .early_latch_strobe_b_o(early_latch_strobe_b_o), .command_b_o(command_b_o),
   .ready_b_o(ready_b_o), .cpu_reset_o(cpu_reset_o), .nmi_o(nmi_o), .quick_mode_o(quick_mode_o),
   .wait8_o(wait8_o), .shadow_write_protect_o(shadow_write_protect_o),
   .rom_select_suppress_o(rom_select_suppress_o), .bus_clk_en_o(bus_clk_en_o),
   .system_clock_o(system_clock_o));

// File: bench/bcm_peer.sv
`timescale 1ns/1ps
module bcm_peer (
   input wire sys_clk_i,
   input wire start_i,
   input wire [7:0] lat_i,
   output reg ready_o,
   output reg async_bus_clock_in_o
);
   reg [8:0] cnt_q;
   initial begin
      ready_o = 1'b0;
      async_bus_clock_in_o = 1'b0;
      cnt_q = 9'h000;
   end
   // free-running bus oscillator, period chosen unrelated to the system clock
   // a 1 ps phase offset keeps its edges off the system clock edges
   initial begin
      #0.001;
      forever #7.3 async_bus_clock_in_o = ~async_bus_clock_in_o;
   end
   always @(posedge sys_clk_i) begin
      ready_o <= 1'b0;
      if (start_i) begin
         cnt_q <= {1'b0, lat_i};
      end else if (cnt_q != 9'h000) begin
         cnt_q <= cnt_q - 9'h001;
         if (cnt_q == 9'h001) ready_o <= 1'b1;
      end
   end
endmodule // bcm_peer

// File: bench/tb.sv
`timescale 1ns/1ps
module tb;
   reg sys_clk_i = 0, rst_b_i = 0, wr_s = 0, rd_s = 0, busc = 0, cst = 0, cop = 1;
   reg [15:0] a = 0;
   reg [7:0] wd = 0, lat = 8'd20, r;
   reg [3:0] fl = 0;
   reg [15:0] e;
   reg [15:0] q[$];
   wire [7:0] rdat;
   wire rdy, async_bus_clock_in, ale, cmd_b, rdy_b, crst, nmi, ext;
   integer num_errors = 0, tests_run = 0, seed = 86380, cyc = 0, i, o1, o2;
   integer n_rst = 0, n_ale = 0, n_cmd = 0;
   localparam [55:0] RI = {8'h60, 8'h61, 8'h62, 8'h64, 8'h65, 8'h66, 8'h67};
   localparam [55:0] RE = {8'h0a, 8'h45, 8'hbc, 8'h00, 8'h0e, 8'h1f, 8'h00};
   localparam [55:0] RM = {8'h3f, 8'hff, 8'hbf, 8'hff, 8'hff, 8'hff, 8'hff};
   localparam [39:0] WI = {8'h61, 8'h64, 8'h65, 8'h66, 8'h67};
   localparam [39:0] WM = {8'hff, 8'h7f, 8'hff, 8'he0, 8'hff};
   always #2.5 sys_clk_i = ~sys_clk_i;
   bcm_peer u_peer (.sys_clk_i(sys_clk_i), .start_i(cst), .lat_i(lat), .ready_o(rdy),
      .async_bus_clock_in_o(async_bus_clock_in));
   bcm_ctrl DUT (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .io_addr_i(a), .io_wdata_i(wd),
      .io_wr_i(wr_s), .io_rd_i(rd_s), .io_rdata_o(rdat), .parity_error_flag_i(fl[3]),
      .channel_check_flag_i(fl[2]), .tone_timer_output_i(fl[1]), .refresh_toggle_i(fl[0]),
      .coproc_present_i(cop), .async_bus_clock_i(async_bus_clock_in), .cycle_start_flag_i(cst),
      .ready_in_i(rdy), .bus_cycle_i(busc), .cpu_clk_en_o(), .bus_clk_en_o(),
      .system_clock_o(), .internal_latch_strobe_o(), .ale_o(ale), .early_latch_strobe_b_o(),
      .command_b_o(cmd_b), .ready_b_o(rdy_b), .cpu_reset_o(crst), .nmi_o(nmi),
      .quick_mode_o(), .external_mode_o(ext), .extra_hold_o(), .wait16_o(), .wait8_o(),
      .coproc_ready_self_o(), .sleep_system_clock_out_sel_o(), .sleep_scale_o(),
      .shadow_write_protect_o(), .rom_select_suppress_o(), .base_ram_map_o(),
      .a_block_shadow_enable_o(), .speaker_bit_o(), .tone_timer_gate_o(),
      .channel_check_enable_o(), .parity_check_enable_o());
   task wrap_up;
      begin
         $display("errors %0d checks %0d", num_errors, tests_run);
         if (num_errors == 0 && tests_run > 0) $display("TB: PASS");
         else $display("TB: FAIL");
         $finish;
      end
   endtask
   task chk(input [7:0] got, input [7:0] exp);
      begin
         tests_run = tests_run + 1;
         if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   // read results are matched against the oldest note when the strobe is taken
   always @(posedge sys_clk_i) begin
      cyc = cyc + 1;
      if (rd_s === 1'b1) begin
         e = q.pop_front();
         chk(rdat & e[7:0], e[15:8]);
      end
      if (rst_b_i && crst === 1'b1) n_rst = n_rst + 1;
      if (rst_b_i && ale === 1'b1) n_ale = n_ale + 1;
      if (rst_b_i && cmd_b === 1'b0) n_cmd = n_cmd + 1;
      if (cyc == 20000) begin
         num_errors = num_errors + 1;
         wrap_up;
      end
   end
   task step(input integer n);
      begin
         repeat (n) @(posedge sys_clk_i);
         #1;
      end
   endtask
   task wr(input [15:0] ad, input [7:0] d);
      begin
         a = ad;
         wd = d;
         wr_s = 1;
         step(1);
         wr_s = 0;
         step(1);
      end
   endtask
   task rdc(input [15:0] ad, input [7:0] ex, input [7:0] m);
      begin
         q.push_back({ex, m});
         a = ad;
         rd_s = 1;
         step(1);
         rd_s = 0;
         step(1);
      end
   endtask
   task ix(input [7:0] x, input [7:0] d);
      begin
         wr(16'h0022, x);
         wr(16'h0023, d);
      end
   endtask
   task ixr(input [7:0] x, input [7:0] ex, input [7:0] m);
      begin
         wr(16'h0022, x);
         rdc(16'h0023, ex, m);
      end
   endtask
   task buscyc;
      integer k;
      begin
         o1 = n_ale;
         o2 = n_cmd;
         busc = 1;
         step(1);
         busc = 0;
         k = 0;
         while (rdy_b !== 1'b0 && k < 400) begin
            step(1);
            k = k + 1;
         end
         chk({k < 400, n_ale > o1, n_cmd > o2}, 8'h07);
         step(2);
      end
   endtask
   task pulse_start;
      begin
         cst = 1;
         step(1);
         cst = 0;
      end
   endtask
   initial begin
      step(16);
      rst_b_i = 1;
      for (i = 0; i < 7; i = i + 1) ixr(RI[55-8*i -: 8], RE[55-8*i -: 8], RM[55-8*i -: 8]);
      rdc(16'h0061, 8'h00, 8'hff);
      rdc(16'h0070, 8'h00, 8'h80);
      rdc(16'h0041, 8'h00, 8'hff);
      for (i = 0; i < 5; i = i + 1) begin
         r = $random(seed);
         ix(WI[39-8*i -: 8], r);
         ixr(WI[39-8*i -: 8], r & WM[39-8*i -: 8], WM[39-8*i -: 8]);
      end
      fl = $random(seed);
      r = $random(seed);
      wr(16'h0061, r);
      rdc(16'h0061, {fl, r[3:0]}, 8'hff);
      wr(16'h0070, 8'h80);
      rdc(16'h0070, 8'h80, 8'h80);
      ix(8'h61, 8'h45);
      ix(8'h64, 8'h00);
      ix(8'h60, 8'h04);
      ix(8'h60, 8'h24);
      ix(8'h60, 8'h24);
      ix(8'h60, 8'h04);
      ix(8'h60, 8'h24);
      chk(n_rst[7:0], 8'h02);
      ix(8'h62, 8'h31);
      ix(8'h60, 8'h14);
      ix(8'h62, 8'h32);
      ixr(8'h62, 8'hb1, 8'hbf);
      ix(8'h60, 8'h04);
      ix(8'h62, 8'h32);
      ixr(8'h62, 8'hb2, 8'hbf);
      pulse_start;
      step(140);
      chk(nmi, 8'h00);
      ixr(8'h60, 8'h00, 8'h01);
      lat = 8'd250;
      pulse_start;
      step(120);
      chk(nmi, 8'h00);
      step(15);
      chk(nmi, 8'h01);
      ixr(8'h60, 8'h05, 8'h05);
      chk(nmi, 8'h00);
      ix(8'h62, 8'h00);
      buscyc;
      ix(8'h62, 8'h02);
      ix(8'h64, 8'h03);
      chk(ext, 8'h01);
      buscyc;
      wrap_up;
   end
endmodule // tb

// File: verilog/bcm_ctrl.v
`timescale 1ns/1ps
`include "bcm_regs.vh"
module bcm_ctrl #(
   parameter [1:0] REV_ID = 2'h0 // revision field, value arbitrary
) (
   input wire sys_clk_i,
   input wire rst_b_i,
   input wire [15:0] io_addr_i,
   input wire [7:0] io_wdata_i,
   input wire io_wr_i,
   input wire io_rd_i,
   output reg [7:0] io_rdata_o,
   input wire parity_error_flag_i,
   input wire channel_check_flag_i,
   input wire tone_timer_output_i,
   input wire refresh_toggle_i,
   input wire coproc_present_i,
   input wire async_bus_clock_i,
   input wire cycle_start_flag_i,
   input wire ready_in_i,
   input wire bus_cycle_i,
   output wire cpu_clk_en_o,
   output wire bus_clk_en_o,
   output reg system_clock_o,
   output reg internal_latch_strobe_o,
   output reg ale_o,
   output reg early_latch_strobe_b_o,
   output reg command_b_o,
   output reg ready_b_o,
   output reg cpu_reset_o,
   output wire nmi_o,
   output wire quick_mode_o,
   output wire external_mode_o,
   output wire extra_hold_o,
   output wire [1:0] wait16_o,
   output wire [1:0] wait8_o,
   output wire coproc_ready_self_o,
   output wire [1:0] sleep_system_clock_out_sel_o,
   output wire [2:0] sleep_scale_o,
   output wire [3:0] shadow_write_protect_o,
   output wire [3:0] rom_select_suppress_o,
   output wire [2:0] base_ram_map_o,
   output wire [7:0] a_block_shadow_enable_o,
   output wire speaker_bit_o,
   output wire tone_timer_gate_o,
   output wire channel_check_enable_o,
   output wire parity_check_enable_o
);
   localparam [5:0] S_IDLE = 6'h01;
   localparam [5:0] S_IAL1 = 6'h02;
   localparam [5:0] S_IAL2 = 6'h04;
   localparam [5:0] S_ALE = 6'h08;
   localparam [5:0] S_CMD = 6'h10;
   localparam [5:0] S_RDY = 6'h20;

   reg [7:0] index_q;
   reg [3:0] sysctl_q;
   reg nmi_en_q;
   reg rst_bit_q;
   reg pclk_sel_q;
   reg tmo_nmi_en_q;
   reg tmo_q;
   reg [7:0] cmddly_q;
   reg [5:0] wait_q;
   reg cop_rdy_q;
   reg [7:0] sleep_q;
   reg [7:0] rom_q;
   reg [2:0] rammap_q;
   reg [7:0] shada_q;
   reg [7:0] tmo_cnt_q;
   reg tmo_run_q;
   reg [2:0] div_q;
   reg [5:0] st_q;
   reg [1:0] dly_q;
   reg [2:0] ws_q;
   reg async_q;
   reg sys_div_q;
   reg bus_en;
   wire wr_data = io_wr_i && (io_addr_i == `BCM_PORT_DATA);
   wire [1:0] src = wait_q[1:0];
   wire [1:0] src64 = sleep_q[1:0];
   // port decodes
   wire wr_index = io_wr_i && (io_addr_i == `BCM_PORT_INDEX);
   wire wr_sysctl = io_wr_i && (io_addr_i == `BCM_PORT_SYSCTL);
   wire wr_nmi = io_wr_i && (io_addr_i == `BCM_PORT_NMI);
   // reading index 60h is what clears the timeout status
   wire rd_pclk = io_rd_i && (io_addr_i == `BCM_PORT_DATA) && (index_q == `BCM_IDX_PCLK);
   wire tmo_set = !ready_in_i && tmo_run_q && (tmo_cnt_q == `BCM_TIMEOUT_CYC - 8'd1);
   // one pulse per rising edge; a level would step the bus once or twice per period
   wire async_rise = async_bus_clock_i && !async_q;
   // divide-by-3 wraps early, the other ratios use the free-running count
   wire div3_wrap = (src == `BCM_SRC_FOLLOW) && (src64 == 2'h0) && (div_q == 3'h2);
   // revision and reserved bits read back as fixed values
   wire [7:0] pclk_rd = {REV_ID, rst_bit_q, pclk_sel_q, 1'b1, tmo_nmi_en_q, 1'b1, tmo_q};

   // external mode when async source selected
   assign external_mode_o = (src == `BCM_SRC_FOLLOW) && (src64 == `BCM_ASYNC_SEL);
   assign quick_mode_o = ~cmddly_q[6];
   assign extra_hold_o = cmddly_q[7];
   assign wait16_o = wait_q[5:4];
   assign wait8_o = wait_q[3:2];
   assign coproc_ready_self_o = ~cop_rdy_q;
   assign sleep_system_clock_out_sel_o = {sleep_q[6], sleep_q[4]};
   assign sleep_scale_o = {sleep_q[5], sleep_q[3], sleep_q[2]};
   assign shadow_write_protect_o = rom_q[7:4];
   assign rom_select_suppress_o = rom_q[3:0];
   assign base_ram_map_o = rammap_q;
   assign a_block_shadow_enable_o = shada_q;
   assign channel_check_enable_o = sysctl_q[3];
   assign parity_check_enable_o = sysctl_q[2];
   assign speaker_bit_o = sysctl_q[1];
   assign tone_timer_gate_o = sysctl_q[0];
   // timeout nmi gated by both enables
   assign nmi_o = tmo_q && tmo_nmi_en_q && nmi_en_q;

   // bus clock enable from selected divider
   always @* begin
      bus_en = 1'b1;
      case (src)
         `BCM_SRC_HALF: bus_en = div_q[0];
         `BCM_SRC_FULL: bus_en = 1'b1;
         `BCM_SRC_FOLLOW: begin
            case (src64)
               2'h0: bus_en = (div_q == 3'h2);
               2'h1: bus_en = (div_q[1:0] == 2'h3);
               2'h2: bus_en = (div_q == 3'h7);
               default: bus_en = async_rise;
            endcase
         end
         default: bus_en = 1'b1;
      endcase
   end
   // one-cycle enable, never a gated clock
   assign bus_clk_en_o = bus_en;
   // processor clock from input or bus clock
   assign cpu_clk_en_o = pclk_sel_q ? bus_en : 1'b1;

   always @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         div_q <= 3'h0;
         async_q <= 1'b0;
         sys_div_q <= 1'b0;
         system_clock_o <= 1'b0;
      end else begin
         if (div3_wrap)
            div_q <= 3'h0;
         else
            div_q <= div_q + 3'h1;
         // inputs synchronous by assumption; one flop edge detect
         async_q <= async_bus_clock_i;
         // system clock is bus clock halved
         if (bus_en)
            sys_div_q <= ~sys_div_q;
         // registered copy keeps the clock output glitch free
         system_clock_o <= sys_div_q;
      end
   end

   always @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         index_q <= 8'h00;
         sysctl_q <= 4'h0;
         nmi_en_q <= 1'b0;
         rst_bit_q <= 1'b0;
         pclk_sel_q <= 1'b0;
         tmo_nmi_en_q <= 1'b0;
         cmddly_q <= `BCM_RST_CMDDLY;
         wait_q <= `BCM_RST_WAIT;
         cop_rdy_q <= 1'b0;
         sleep_q <= 8'h00;
         rom_q <= `BCM_RST_ROM;
         rammap_q <= 3'h0;
         shada_q <= `BCM_RST_SHADA;
         cpu_reset_o <= 1'b0;
      end else begin
         // reset pulse lasts one clock
         cpu_reset_o <= 1'b0;
         if (wr_index)
            index_q <= io_wdata_i;
         if (wr_sysctl)
            sysctl_q <= io_wdata_i[3:0];
         if (wr_nmi)
            nmi_en_q <= io_wdata_i[7];
         if (wr_data) begin
            case (index_q)
               `BCM_IDX_PCLK: begin
                  cpu_reset_o <= io_wdata_i[5] & ~rst_bit_q;
                  rst_bit_q <= io_wdata_i[5];
                  pclk_sel_q <= io_wdata_i[4];
                  tmo_nmi_en_q <= io_wdata_i[2];
               end
               `BCM_IDX_CMDDLY: cmddly_q <= io_wdata_i;
               `BCM_IDX_WAIT: begin
                  cop_rdy_q <= io_wdata_i[6];
                  wait_q[5:2] <= io_wdata_i[5:2];
                  // locked while cpu runs on bus clock
                  if (!pclk_sel_q)
                     wait_q[1:0] <= io_wdata_i[1:0];
               end
               `BCM_IDX_SLEEP: sleep_q <= io_wdata_i;
               `BCM_IDX_ROM: rom_q <= io_wdata_i;
               `BCM_IDX_RAMMAP: rammap_q <= io_wdata_i[7:5];
               `BCM_IDX_SHADA: shada_q <= io_wdata_i;
               default: ;
            endcase
         end
      end
   end

   // timeout counter, status clears on reread of 60h
   always @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         tmo_cnt_q <= 8'h00;
         tmo_run_q <= 1'b0;
         tmo_q <= 1'b0;
      end else begin
         if (ready_in_i) begin
            tmo_run_q <= 1'b0;
            tmo_cnt_q <= 8'h00;
         end else if (cycle_start_flag_i && !tmo_run_q) begin
            tmo_run_q <= 1'b1;
            tmo_cnt_q <= 8'h01;
         end else if (tmo_run_q) begin
            if (tmo_set) begin
               tmo_q <= 1'b1;
               tmo_run_q <= 1'b0;
            end
            // counter parks past the limit until ready or the next start
            tmo_cnt_q <= tmo_cnt_q + 8'h01;
         end
         // set beats the read-clear
         if (rd_pclk && !tmo_set)
            tmo_q <= 1'b0;
      end
   end

   // read data follows the address within the cycle
   always @* begin
      io_rdata_o = 8'h00;
      if (io_addr_i == `BCM_PORT_SYSCTL)
         io_rdata_o = {parity_error_flag_i, channel_check_flag_i, tone_timer_output_i,
                       refresh_toggle_i, sysctl_q};
      else if (io_addr_i == `BCM_PORT_NMI)
         io_rdata_o = {nmi_en_q, 7'h00};
      else if (io_addr_i == `BCM_PORT_INDEX)
         io_rdata_o = index_q;
      else if (io_addr_i == `BCM_PORT_DATA) begin
         case (index_q)
            `BCM_IDX_PCLK: io_rdata_o = pclk_rd;
            `BCM_IDX_CMDDLY: io_rdata_o = cmddly_q;
            `BCM_IDX_WAIT: io_rdata_o = {coproc_present_i, cop_rdy_q, wait_q};
            `BCM_IDX_SLEEP: io_rdata_o = sleep_q;
            `BCM_IDX_ROM: io_rdata_o = rom_q;
            `BCM_IDX_RAMMAP: io_rdata_o = {rammap_q, 5'h1f};
            `BCM_IDX_SHADA: io_rdata_o = shada_q;
            default: io_rdata_o = 8'h00;
         endcase
      end
   end

   // bus cycle sequencer, bus steps on bus clock enable
   always @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         st_q <= S_IDLE;
         dly_q <= 2'h0;
         ws_q <= 3'h0;
         internal_latch_strobe_o <= 1'b0;
         ale_o <= 1'b0;
         early_latch_strobe_b_o <= 1'b1;
         command_b_o <= 1'b1;
         ready_b_o <= 1'b1;
      end else begin
         ready_b_o <= 1'b1;
         case (st_q)
            S_IDLE: begin
               // only bus cycles get latch and command
               if (bus_cycle_i) begin
                  internal_latch_strobe_o <= 1'b1;
                  // early strobe holds upper address through latch
                  early_latch_strobe_b_o <= 1'b0;
                  st_q <= S_IAL1;
               end
            end
            S_IAL1: st_q <= S_IAL2;
            S_IAL2: begin
               // strobe drops even while the bus clock is awaited
               internal_latch_strobe_o <= 1'b0;
               if (bus_en) begin
                  ale_o <= 1'b1;
                  dly_q <= cmddly_q[5:4];
                  // only 16-bit memory timing is sequenced
                  ws_q <= {1'b0, wait_q[5:4]};
                  st_q <= S_ALE;
               end
            end
            S_ALE: begin
               if (bus_en) begin
                  ale_o <= 1'b0;
                  // early strobe releases with the bus latch
                  early_latch_strobe_b_o <= 1'b1;
                  if (dly_q == 2'h0) begin
                     command_b_o <= 1'b0;
                     st_q <= S_CMD;
                  end else
                     dly_q <= dly_q - 2'h1;
               end
            end
            S_CMD: begin
               if (bus_en) begin
                  if (ws_q == 3'h0) begin
                     command_b_o <= 1'b1;
                     st_q <= S_RDY;
                  end else
                     ws_q <= ws_q - 3'h1;
               end
            end
            S_RDY: begin
               // inactive command seen on input clock, ready follows
               if (command_b_o) begin
                  ready_b_o <= 1'b0;
                  st_q <= S_IDLE;
               end
            end
            default: st_q <= S_IDLE;
         endcase
      end
   end
endmodule // bcm_ctrl

// File: verilog/bcm_regs.vh
// Contract
// - quick mode off selects delayed mode; bus clock equals input clock, system clock half; here bus clock set by index 62h bits 1:0, reset half input clock.
// - delayed mode: internal latch steps 1-2, bus latch asserted step 3, dropped step 4.
// - upper local address invalid during latch; early latch strobe provided to hold them.
// - async clock source selects external mode; bus clock follows it, system clock half.
// - external mode bus sequencing runs on bus clock; commands only for bus cycles.
// - external mode samples inactive command each input clock edge, then asserts ready.
// - port 61h: bits 7-4 read-only flags, bits 3-0 read/write, reset zero.
// - nmi_gate_port implements only bit 7, nmi enable, reset zero.
// - index written to port 22h, data accessed at port 23h.
// - rising edge written to index 60h bit 5 triggers cpu reset.
// - index 60h bit 4 selects processor clock, 0 input clock, reset 0.
// - index 60h bit 0 flags ready timeout after 128 cycles; bit 2 enables nmi.
// - index 61h bit 7 extra hold, reset 0; bit 6 quick mode disable, reset 1.
// - index 61h three 2-bit command delay fields, 0 to 3 bus clocks; here only bits 5:4 delay the command, the other fields are stored only.
// - index 62h 16-bit waits 0-3, 8-bit waits 2-5, both reset 11.
// - index 62h bits 1:0 bus clock source; write ignored while 60h bit 4 set.
// - index 62h bit 7 coprocessor present read-only; bit 6 ready source.
// - sleep_async_clock_select bits 6,4 sleep system clock select; scaling bits 5,3,2 stored.
// - index 65h bits 7-4 shadow write protect, bits 3-0 suppress rom select.
// - base_ram_mapping bit 7 maps 512k-640k on board; bits 6,5 inverted polarity.
// - shadow_enable_a_segment bits enable a-segment 16k shadow blocks.
`ifndef BCM_REGS_VH
`define BCM_REGS_VH
`define BCM_PORT_SYSCTL 16'h0061
`define BCM_PORT_NMI 16'h0070
`define BCM_PORT_INDEX 16'h0022
`define BCM_PORT_DATA 16'h0023
`define BCM_IDX_PCLK 8'h60
`define BCM_IDX_CMDDLY 8'h61
`define BCM_IDX_WAIT 8'h62
`define BCM_IDX_SLEEP 8'h64
`define BCM_IDX_ROM 8'h65
`define BCM_IDX_RAMMAP 8'h66
`define BCM_IDX_SHADA 8'h67
`define BCM_RST_CMDDLY 8'h45
`define BCM_RST_WAIT 6'h3c
`define BCM_RST_ROM 8'h0e
`define BCM_RST_SHADA 8'h00
`define BCM_TIMEOUT_CYC 8'd128
`define BCM_SRC_HALF 2'h0
`define BCM_SRC_FULL 2'h1
`define BCM_SRC_FOLLOW 2'h2
`define BCM_ASYNC_SEL 2'h3
`define BCM_SLP_DIV4 2'h0
`define BCM_SLP_STATIC 2'h1
`define BCM_SLP_BUSHALF 2'h2
`define BCM_DLY_W 2
`endif
